// File: bench/alu_op_cycle_timing_asserts.sv
// Port-level assertions for the operation cycle-count unit
`timescale 1ns/1ps
`default_nettype none
module alu_op_cycle_timing_asserts (
  // Request side
  input wire logic                         clock,
  input wire logic                         rst_b,
  input wire logic                         start,
  input wire alu_timing_pkg::op_t          op,
  input wire alu_timing_pkg::size_t        op_size,
  input wire alu_timing_pkg::dest_t        dest,
  input wire alu_timing_pkg::locator_t     src_locator,
  input wire logic [15:0]                  src_value,
  input wire logic [7:0]                   ea_clocks,
  input wire logic [3:0]                   ea_reads,
  // Report side
  input wire logic                         busy,
  input wire logic                         next_fetch,
  input wire logic                         illegal,
  input wire logic [9:0]                   total_clocks,
  input wire logic [4:0]                   total_reads,
  input wire logic [4:0]                   total_writes
);
  import alu_timing_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_take(o, s, d, l);
    start && !busy && op == o && op_size == s && dest == d && src_locator == l;
  endsequence
  // Busy cycles seen so far, compared with the reported total when busy ends
  logic [9:0] span_reg;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) span_reg <= 10'h000;
    else span_reg <= busy ? span_reg + 10'h001 : 10'h000;
  a_span_matches: assert property ($fell(busy) |-> span_reg == total_clocks && next_fetch)
    else $error("busy span differs from reported clocks");
  a_take_starts: assert property (start && !busy |=> busy || illegal)
    else $error("accepted request neither counting nor refused");
  a_illegal_done: assert property (start && !busy ##1 illegal |-> next_fetch && !busy)
    else $error("illegal request did not finish at once");
  a_refuse_busy: assert property (busy && start |=> $stable(total_clocks))
    else $error("request taken while busy");
  a_quick_load: assert property (s_take(quick_constant_load, size_long,
    dest_data_register_operand, loc_immediate) |=> total_clocks == 10'h008 &&
    total_reads == 5'h02 && total_writes == 5'h00)
    else $error("quick constant load timing wrong");
  a_immediate_logical_and_byte: assert property (s_take(immediate_logical_and, size_byte,
    dest_data_register_operand, loc_immediate) |=> total_clocks == 10'h010 &&
    total_reads == 5'h04 && total_writes == 5'h00)
    else $error("byte immediate and timing wrong");
  a_divide_max: assert property (s_take(signed_divide, size_word, dest_data_register_operand,
    loc_indirect) |=> total_clocks == 10'ha2 + $past(ea_clocks)
    && total_reads == 5'h02 + $past(ea_reads))
    else $error("signed divide timing wrong");
  a_umul_count: assert property (s_take(unsigned_multiply, size_word,
    dest_data_register_operand, loc_indirect) |=> total_clocks ==
    42 + 2 * $countones($past(src_value)) + $past(ea_clocks))
    else $error("unsigned multiply clocks wrong");
  a_smul_count: assert property (s_take(signed_multiply, size_word,
    dest_data_register_operand, loc_indirect) |=> total_clocks == 42 + $past(ea_clocks)
    + 2 * $countones($past(src_value) ^ ($past(src_value) >> 1)))
    else $error("signed multiply clocks wrong");
  a_long_bump: assert property (s_take(add_op, size_long, dest_data_register_operand,
    loc_data_register_operand) |=> total_clocks == 10'h00c + $past(ea_clocks))
    else $error("long register source bump missing");
endmodule
bind alu_op_cycle_timing alu_op_cycle_timing_asserts alu_op_cycle_timing_asserts_i (
  .clock, .rst_b, .start, .op, .op_size, .dest, .src_locator, .src_value, .ea_clocks,
  .ea_reads, .busy, .next_fetch, .illegal, .total_clocks, .total_reads, .total_writes);
`default_nettype wire

// File: bench/ea_stage_model.sv
// Address-evaluation stage model that supplies operand locator time
`timescale 1ns/1ps
`default_nettype none
module ea_stage_model #(
  parameter logic [7:0] MEM_CLOCKS = 8'h04,
  parameter logic [3:0] MEM_READS  = 4'h1
) (
  input  wire alu_timing_pkg::locator_t src_locator,
  output logic [7:0]                    ea_clocks,
  output logic [3:0]                    ea_reads,
  output logic [3:0]                    ea_writes
);
  import alu_timing_pkg::*;
  logic reg_direct;
  // Register and immediate sources kept free so the long bump shows alone
  assign reg_direct = src_locator inside {loc_data_register_operand,
    loc_address_register_operand, loc_immediate};
  assign ea_clocks = reg_direct ? 8'h00 : MEM_CLOCKS;
  assign ea_reads  = reg_direct ? 4'h0 : MEM_READS;
  assign ea_writes = 4'h0;
endmodule
`default_nettype wire

// File: bench/tb_alu_op_cycle_timing.sv
// Self-checking testbench for the operation cycle-count unit
`timescale 1ns/1ps
`default_nettype none
module tb_alu_op_cycle_timing;
  import alu_timing_pkg::*;
  localparam dest_t    DREG = dest_data_register_operand;
  localparam locator_t LDAT = loc_data_register_operand;
  localparam locator_t LIND = loc_indirect;
  localparam locator_t LIMM = loc_immediate;
  logic clock, rst_b, start, busy, next_fetch, illegal;
  op_t op;
  size_t op_size;
  dest_t dest;
  locator_t src_locator;
  logic [15:0] src_value;
  logic [7:0] ea_clocks;
  logic [3:0] ea_reads, ea_writes;
  logic [9:0] total_clocks;
  logic [4:0] total_reads, total_writes;
  int errors, n_compared;
  ea_stage_model #(.MEM_CLOCKS(8'h04), .MEM_READS(4'h1)) ea_stage_model_i (.src_locator,
    .ea_clocks, .ea_reads, .ea_writes);
  alu_op_cycle_timing alu_op_cycle_timing_i (.clock, .rst_b, .start, .op, .op_size, .dest,
    .src_locator, .src_value, .ea_clocks, .ea_reads, .ea_writes, .busy, .next_fetch,
    .illegal, .total_clocks, .total_reads, .total_writes);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(logic [15:0] seen, logic [15:0] expd);
    n_compared++;
    if (seen !== expd) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  // Zero counts mean a refused combination; nag adds a request while busy
  task automatic run(op_t o, size_t s, dest_t d, locator_t l, logic [15:0] v,
                     logic [15:0] c, logic [15:0] r, logic [15:0] w, logic nag);
    int n;
    @(posedge clock);
    start <= 1'b1;
    op <= o;
    op_size <= s;
    dest <= d;
    src_locator <= l;
    src_value <= v;
    @(posedge clock);
    start <= nag;
    op <= signed_divide;
    #1;
    check(illegal, (c | r | w) == 16'h0000);
    check(total_reads, r);
    check(total_writes, w);
    n = 0;
    while (next_fetch !== 1'b1 && n < 400) begin
      @(posedge clock);
      start <= 1'b0;
      #1;
      n++;
    end
    check(n, c);
    check(total_clocks, c);
    check(busy, 1'b0);
  endtask
  task automatic t_quick;
    run(quick_constant_load, size_long, DREG, LIMM, 16'h0000, 8, 2, 0, 1);
    run(quick_constant_load, size_byte, DREG, LIMM, 16'h0000, 0, 0, 0, 0);
    $display("quick load test done");
  endtask
  task automatic t_immediate_logical_and;
    run(immediate_logical_and, size_byte, DREG, LIMM, 16'h0000, 16, 4, 0, 0);
    run(immediate_logical_and, size_byte, dest_memory, LIND, 16'h0000, 24, 5, 1, 0);
    $display("immediate and test done");
  endtask
  task automatic t_mul;
    logic [15:0] vals [4];
    vals = '{16'h5555, 16'h0000, 16'hffff, 16'h8001};
    foreach (vals[i]) begin
      run(unsigned_multiply, size_word, DREG, LIND, vals[i],
          46 + 2 * $countones(vals[i]), 3, 0, 0);
      run(signed_multiply, size_word, DREG, LIND, vals[i],
          46 + 2 * $countones(vals[i] ^ (vals[i] >> 1)), 3, 0, 0);
    end
    $display("multiply test done");
  endtask
  task automatic t_div;
    run(signed_divide, size_word, DREG, LIND, 16'h0000, 166, 3, 0, 0);
    run(unsigned_divide, size_word, DREG, LIND, 16'h0000, 148, 3, 0, 0);
    run(unsigned_divide, size_word, DREG, LIND, 16'hffff, 148, 3, 0, 0);
    run(signed_divide, size_word, DREG, LIND, 16'h8001, 166, 3, 0, 0);
    $display("divide test done");
  endtask
  // Columns and operations not reached by the scenarios above
  task automatic t_columns;
    run(sub_op, size_word, dest_address_register_operand, LDAT, 16'h0000, 12, 2, 0, 0);
    run(sub_op, size_byte, dest_address_register_operand, LDAT, 16'h0000, 0, 0, 0, 0);
    run(or_op, size_word, dest_memory, LIND, 16'h0000, 20, 3, 2, 0);
    run(and_op, size_long, DREG, LIMM, 16'h0000, 12, 2, 0, 0);
    run(compare_op, size_byte, dest_address_register_operand, LDAT, 16'h0000, 0, 0, 0, 0);
    run(compare_immediate, size_long, dest_memory, LIND, 16'h0000, 24, 6, 0, 0);
    run(sub_immediate, size_byte, dest_memory, LIND, 16'h0000, 16, 3, 1, 0);
    run(xor_immediate, size_long, DREG, LIMM, 16'h0000, 28, 6, 0, 0);
    run(add_quick, size_long, DREG, LIMM, 16'h0000, 12, 2, 0, 0);
    run(sub_quick, size_word, dest_address_register_operand, LIMM, 16'h0000, 12, 2, 0, 1);
    run(sub_quick, size_byte, dest_memory, LIND, 16'h0000, 24, 5, 1, 0);
    $display("column coverage test done");
  endtask
  task automatic t_bump;
    run(add_op, size_long, DREG, LDAT, 16'h0000, 12, 2, 0, 0);
    run(add_op, size_long, DREG, LIND, 16'h0000, 14, 3, 0, 0);
    run(compare_op, size_long, DREG, LDAT, 16'h0000, 10, 2, 0, 0);
    run(exclusive_or_op, size_long, DREG, LDAT, 16'h0000, 12, 2, 0, 0);
    run(exclusive_or_op, size_long, DREG, LIND, 16'h0000, 0, 0, 0, 0);
    $display("long and exclusive-or test done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #60000;
    errors++;
    tally_and_finish;
  end
  initial begin
    errors = 0;
    n_compared = 0;
    rst_b = 1'b0;
    start = 1'b0;
    op = add_op;
    op_size = size_byte;
    dest = DREG;
    src_locator = LDAT;
    src_value = 16'h0000;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_quick;
    t_immediate_logical_and;
    t_mul;
    t_div;
    t_bump;
    t_columns;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// File: logic/alu_op_cycle_timing.sv
// Cycle-count timing unit for two-operand and immediate ALU operations
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RULE_01] Duration covers compute, result write-back and next instruction fetch.
// [RULE_02] Entries marked for address time add its clocks, reads and writes.
// [RULE_03] Duration reported as total clocks, bus reads and bus writes.
// [RULE_04] Long base of ten becomes twelve for register-direct or immediate sources; compare_op long keeps ten.
// [RULE_05] Exclusive-or into data register accepts only a data register source.
// [RULE_06] Divide 162 signed, 144 unsigned, multiply 74 maximum, two reads, plus address.
// [RULE_07] Divide best and worst durations stay within ten percent.
// [RULE_08] Multiply takes 42 plus twice n clock periods.
// [RULE_09] Signed multiply n counts differing adjacent pairs of zero-extended source.
// [RULE_10] Unsigned multiply n is the number of set source bits.
// [RULE_11] Immediate operations include the reads that fetch the immediate value; sub_immediate into memory uses the plain mem_rmw entry without them.
// [RULE_12] Quick constant load takes 8 clocks, two reads, no writes.
// [RULE_13] Byte immediate AND into data register takes 16 clocks, four reads.
// [RULE_14] Counter loaded with base plus address time; next instruction on expiry.
module alu_op_cycle_timing (
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                rst_b,
  // Operation request
  input  wire logic                                start,
  input  wire alu_timing_pkg::op_t                 op,
  input  wire alu_timing_pkg::size_t               op_size,
  input  wire alu_timing_pkg::dest_t               dest,
  input  wire alu_timing_pkg::locator_t            src_locator,
  input  wire logic [alu_timing_pkg::SRC_W-1:0]    src_value,
  // Operand address evaluation time from the address stage
  input  wire logic [alu_timing_pkg::EA_CLK_W-1:0] ea_clocks,
  input  wire logic [alu_timing_pkg::EA_BUS_W-1:0] ea_reads,
  input  wire logic [alu_timing_pkg::EA_BUS_W-1:0] ea_writes,
  // Duration report
  output logic                                     busy,
  output logic                                     next_fetch,
  output logic                                     illegal,
  output logic [alu_timing_pkg::CLK_W-1:0]         total_clocks,
  output logic [alu_timing_pkg::BUS_W-1:0]         total_reads,
  output logic [alu_timing_pkg::BUS_W-1:0]         total_writes
);
  import alu_timing_pkg::*;

  function automatic logic [15:0] mem_rmw(input size_t sz);
    mem_rmw = (sz == size_byte) ? T_12_2_1 : (sz == size_word) ? T_16_2_2 : T_24_2_4;
  endfunction

  function automatic logic [15:0] imm_mem(input size_t sz);
    imm_mem = (sz == size_byte) ? T_20_4_1 : (sz == size_word) ? T_24_4_2 : T_40_6_4;
  endfunction

  function automatic logic [15:0] imm_reg(input size_t sz);
    imm_reg = (sz == size_long) ? T_28_6_0 : T_16_4_0;
  endfunction

  function automatic logic [4:0] popcount(input logic [SRC_W-1:0] v);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < SRC_W; i++) begin
      c = c + {4'h0, v[i]};
    end
    popcount = c;
  endfunction

  // Returns {valid, add_ea_time, entry}
  function automatic logic [17:0] lookup(input op_t o, input size_t sz, input dest_t ds,
                                         input locator_t loc);
    logic [15:0] e;
    logic        v;
    logic        a;
    logic        lng;
    e = T_NONE;
    v = 1'b1;
    a = 1'b1;
    lng = (sz == size_long);
    case (o)
      add_op, sub_op: begin
        if (ds == dest_address_register_operand) begin
          v = (sz != size_byte);
          e = lng ? T_10_2_0 : T_12_2_0;
        end else if (ds == dest_data_register_operand) begin
          e = lng ? T_10_2_0 : T_8_2_0;
        end else begin
          e = mem_rmw(sz);
        end
      end
      and_op, or_op: begin
        v = (ds != dest_address_register_operand);
        e = (ds == dest_memory) ? mem_rmw(sz) : (lng ? T_10_2_0 : T_8_2_0);
      end
      compare_op: begin
        v = (ds != dest_memory) && !(ds == dest_address_register_operand && sz == size_byte);
        e = (ds == dest_address_register_operand || lng) ? T_10_2_0 : T_8_2_0;
      end
      exclusive_or_op: begin
        if (ds == dest_data_register_operand) begin
          v = (loc == loc_data_register_operand); // [RULE_05]
          e = lng ? T_12_2_0 : T_8_2_0;
        end else begin
          v = (ds == dest_memory);
          e = mem_rmw(sz);
        end
      end
      signed_divide: begin
        v = (ds == dest_data_register_operand);
        e = T_162_2_0; // [RULE_06] [RULE_07]
      end
      unsigned_divide: begin
        v = (ds == dest_data_register_operand);
        e = T_144_2_0; // [RULE_06] [RULE_07]
      end
      signed_multiply, unsigned_multiply: begin
        v = (ds == dest_data_register_operand);
        e = T_74_2_0; // [RULE_06]
      end
      add_immediate, immediate_logical_and, or_immediate, xor_immediate: begin
        v = (ds != dest_address_register_operand);
        a = (ds == dest_memory);
        e = (ds == dest_memory) ? imm_mem(sz) : imm_reg(sz); // [RULE_11] [RULE_13]
      end
      sub_immediate: begin
        v = (ds != dest_address_register_operand);
        a = (ds == dest_memory);
        e = (ds == dest_memory) ? mem_rmw(sz) : imm_reg(sz); // [RULE_11]
      end
      compare_immediate: begin
        v = (ds != dest_address_register_operand);
        a = 1'b0;
        if (ds == dest_memory) begin
          e = lng ? T_24_6_0 : T_16_4_0;
        end else begin
          e = lng ? T_26_6_0 : T_16_4_0;
        end
      end
      add_quick: begin
        v = (ds != dest_address_register_operand);
        a = (ds == dest_memory);
        e = (ds == dest_memory) ? mem_rmw(sz) : (lng ? T_12_2_0 : T_8_2_0);
      end
      sub_quick: begin
        v = !(ds == dest_address_register_operand && sz == size_byte);
        a = (ds == dest_memory);
        if (ds == dest_memory) begin
          e = imm_mem(sz);
        end else begin
          e = (lng || ds == dest_address_register_operand) ? T_12_2_0 : T_8_2_0;
        end
      end
      quick_constant_load: begin
        v = (ds == dest_data_register_operand) && lng;
        a = 1'b0;
        e = T_8_2_0; // [RULE_12]
      end
      default: begin
        v = 1'b0;
        e = T_NONE;
      end
    endcase
    lookup = {v, a, e};
  endfunction

  // Table decode
  wire logic [17:0] entry_word = lookup(op, op_size, dest, src_locator);
  wire logic        entry_valid = entry_word[17];
  wire logic        entry_adds_ea = entry_word[16];
  wire logic [7:0]  base_clocks = entry_word[ENTRY_CLK_HI:ENTRY_CLK_LO];
  wire logic [3:0]  base_reads = entry_word[ENTRY_RD_HI:ENTRY_RD_LO];
  wire logic [3:0]  base_writes = entry_word[ENTRY_WR_HI:ENTRY_WR_LO];

  // Long-size bump for register-direct or immediate sources
  wire logic src_direct = (src_locator == loc_data_register_operand)
                       || (src_locator == loc_address_register_operand)
                       || (src_locator == loc_immediate);
  wire logic bump_op = (op == add_op) || (op == sub_op)
                    || (((op == and_op) || (op == or_op))
                        && (dest == dest_data_register_operand));
  wire logic bump = bump_op && (op_size == size_long) && src_direct
                 && (dest != dest_memory); // [RULE_04]

  // Data-dependent multiply count
  wire logic [SRC_W:0] src_tagged = {1'b0, src_value};
  wire logic [4:0]     n_signed = popcount(src_tagged[SRC_W:1] ^ src_tagged[SRC_W-1:0]); // [RULE_09]
  wire logic [4:0]     n_unsigned = popcount(src_value); // [RULE_10]
  wire logic           is_mul = (op == signed_multiply) || (op == unsigned_multiply);
  wire logic [4:0]     mul_n = (op == signed_multiply) ? n_signed : n_unsigned;
  // Actual multiply time replaces the 74-clock maximum
  wire logic [7:0]     mul_clocks = MUL_BASE_CLOCKS + {2'b00, mul_n, 1'b0}; // [RULE_08]

  wire logic [7:0] op_clocks = is_mul ? mul_clocks
                             : (bump ? base_clocks + LONG_BUMP_CLOCKS : base_clocks);

  // Address evaluation add-on
  wire logic [EA_CLK_W-1:0] add_clocks = entry_adds_ea ? ea_clocks : '0; // [RULE_02]
  wire logic [EA_BUS_W-1:0] add_reads = entry_adds_ea ? ea_reads : '0;
  wire logic [EA_BUS_W-1:0] add_writes = entry_adds_ea ? ea_writes : '0;

  // Totals include compute, write-back and next fetch as the entries do
  wire logic [CLK_W-1:0] sum_clocks = {2'b00, op_clocks} + {2'b00, add_clocks}; // [RULE_01]
  wire logic [BUS_W-1:0] sum_reads = {1'b0, base_reads} + {1'b0, add_reads}; // [RULE_03]
  wire logic [BUS_W-1:0] sum_writes = {1'b0, base_writes} + {1'b0, add_writes}; // [RULE_03]

  logic [CLK_W-1:0] count_reg;

  wire logic accept = start && !busy;
  wire logic expire = busy && (count_reg == COUNT_LAST);

  // Per-operation countdown
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
      busy <= 1'b0;
    end else if (accept && entry_valid) begin
      count_reg <= sum_clocks; // [RULE_14]
      busy <= 1'b1;
    end else if (expire) begin
      count_reg <= '0;
      busy <= 1'b0;
    end else if (busy) begin
      count_reg <= count_reg - COUNT_LAST;
    end
  end

  // Report registers; an illegal combination finishes at once with zero counts
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      next_fetch <= 1'b0;
      illegal <= 1'b0;
      total_clocks <= '0;
      total_reads <= '0;
      total_writes <= '0;
    end else begin
      next_fetch <= expire || (accept && !entry_valid); // [RULE_14]
      if (accept) begin
        illegal <= !entry_valid;
        total_clocks <= entry_valid ? sum_clocks : '0;
        total_reads <= entry_valid ? sum_reads : '0;
        total_writes <= entry_valid ? sum_writes : '0;
      end
    end
  end

endmodule
`default_nettype wire

// File: logic/alu_timing_pkg.sv
// Shared types and timing constants for the operation cycle-count unit
package alu_timing_pkg;

  // Operations whose durations this unit produces
  typedef enum logic [4:0] {
    add_op,
    sub_op,
    and_op,
    or_op,
    compare_op,
    exclusive_or_op,
    signed_divide,
    unsigned_divide,
    signed_multiply,
    unsigned_multiply,
    add_immediate,
    sub_immediate,
    immediate_logical_and,
    or_immediate,
    xor_immediate,
    compare_immediate,
    add_quick,
    sub_quick,
    quick_constant_load
  } op_t;

  typedef enum logic [1:0] {
    size_byte,
    size_word,
    size_long
  } size_t;

  // Destination column of the timing tables
  typedef enum logic [1:0] {
    dest_address_register_operand,
    dest_data_register_operand,
    dest_memory
  } dest_t;

  // Source operand_locator addressing forms
  typedef enum logic [3:0] {
    loc_data_register_operand,
    loc_address_register_operand,
    loc_indirect,
    loc_post_increment,
    loc_pre_decrement,
    loc_displacement,
    loc_indexed,
    loc_absolute_short,
    loc_absolute_long,
    loc_pc_displacement,
    loc_pc_indexed,
    loc_immediate
  } locator_t;

  localparam int CLK_W = 10;
  localparam int EA_CLK_W = 8;
  localparam int EA_BUS_W = 4;
  localparam int BUS_W = 5;
  localparam int SRC_W = 16;

  // Entries packed as {clocks[15:8], reads[7:4], writes[3:0]}
  localparam logic [15:0] T_NONE = 16'h0000;
  localparam logic [15:0] T_8_2_0 = 16'h0820;
  localparam logic [15:0] T_10_2_0 = 16'h0a20;
  localparam logic [15:0] T_12_2_0 = 16'h0c20;
  localparam logic [15:0] T_12_2_1 = 16'h0c21;
  localparam logic [15:0] T_16_2_2 = 16'h1022;
  localparam logic [15:0] T_24_2_4 = 16'h1824;
  localparam logic [15:0] T_16_4_0 = 16'h1040;
  localparam logic [15:0] T_28_6_0 = 16'h1c60;
  localparam logic [15:0] T_26_6_0 = 16'h1a60;
  localparam logic [15:0] T_24_6_0 = 16'h1860;
  localparam logic [15:0] T_20_4_1 = 16'h1441;
  localparam logic [15:0] T_24_4_2 = 16'h1842;
  localparam logic [15:0] T_40_6_4 = 16'h2864;
  localparam logic [15:0] T_162_2_0 = 16'ha220;
  localparam logic [15:0] T_144_2_0 = 16'h9020;
  localparam logic [15:0] T_74_2_0 = 16'h4a20;

  localparam logic [7:0] LONG_BUMP_CLOCKS = 8'h02;
  localparam logic [7:0] MUL_BASE_CLOCKS = 8'h2a;
  localparam int ENTRY_CLK_HI = 15;
  localparam int ENTRY_CLK_LO = 8;
  localparam int ENTRY_RD_HI = 7;
  localparam int ENTRY_RD_LO = 4;
  localparam int ENTRY_WR_HI = 3;
  localparam int ENTRY_WR_LO = 0;
  localparam logic [CLK_W-1:0] COUNT_LAST = 10'h001;

endpackage
